// ===== src/uepcs_defines.vh
// Constants for the endpoint control and status block
`ifndef UEPCS_DEFINES_VH
`define UEPCS_DEFINES_VH

// Register placement
`define UEPCS_CSR_BASE 8'h20
`define UEPCS_CSR_STRIDE 8'h04
`define UEPCS_EP_FIRST 1
`define UEPCS_EP_LAST 4

// Field positions
`define UEPCS_B_OUT_STALL 21
`define UEPCS_B_OUT_DISCARD 20
`define UEPCS_B_OUT_ERR 19
`define UEPCS_B_OUT_OVER 18
`define UEPCS_B_OCC_HI 17
`define UEPCS_B_OCC_LO 16
`define UEPCS_B_OUT_READY 16
`define UEPCS_B_IN_AUTO 15
`define UEPCS_B_IN_ISO 14
`define UEPCS_B_DIR_IN 13
`define UEPCS_B_DMA_EN 12
`define UEPCS_B_DMA_MARK 11
`define UEPCS_B_OUT_AUTOCLR 9
`define UEPCS_B_OUT_ISO 8
`define UEPCS_B_SIZE_GUARD 7
`define UEPCS_B_MAX_PACKET_SIZE_HI 3
`define UEPCS_B_MAX_PACKET_SIZE_LO 0

// Reset values
`define UEPCS_RST_DIR_IN 1'b1
`define UEPCS_RST_MAX_PACKET_SIZE 4'h1
`define UEPCS_RST_BIT 1'b0

// Occupancy codes
`define UEPCS_OCC_EMPTY 2'h0
`define UEPCS_OCC_ONE 2'h1
`define UEPCS_OCC_FULL 2'h3

// Packet slot counts
`define UEPCS_CNT_ZERO 2'h0
`define UEPCS_CNT_ONE 2'h1
`define UEPCS_CNT_TWO 2'h2

// Size field scaling: multiples of eight bytes
`define UEPCS_MAX_PACKET_SIZE_ZERO 4'h0
`define UEPCS_MAX_PACKET_SIZE_SHIFT 3
`define UEPCS_BYTE_ONE 7'h01
`define UEPCS_BYTE_ZERO 7'h00

`endif

// ===== src/uepcs_pkt_track.v
// Two-slot tracker of received OUT packets with per-packet error and size marks
`timescale 1ns/10ps
module uepcs_pkt_track
(
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire push_err,
  input wire push_big,
  input wire pop,
  output wire [1:0] occupancy,
  output wire head_err,
  output wire ready,
  output wire full
);
`include "uepcs_defines.vh"

  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg err0_q;
  reg err0_d;
  reg err1_q;
  reg err1_d;
  reg big0_q;
  reg big0_d;
  reg big1_q;
  reg big1_d;

  // Head slot is always the packet due for unload; later errors wait behind it
  always @*
  begin
    cnt_d = cnt_q;
    err0_d = err0_q;
    err1_d = err1_q;
    big0_d = big0_q;
    big1_d = big1_q;
    if (pop && cnt_q != `UEPCS_CNT_ZERO)
    begin
      err0_d = err1_q;
      big0_d = big1_q;
      err1_d = `UEPCS_RST_BIT;
      big1_d = `UEPCS_RST_BIT;
      cnt_d = cnt_q - `UEPCS_CNT_ONE;
    end
    if (push)
    begin
      if (cnt_d == `UEPCS_CNT_ZERO)
      begin
        err0_d = push_err;
        big0_d = push_big;
      end
      else
      begin
        err1_d = push_err;
        big1_d = push_big;
      end
      cnt_d = cnt_d + `UEPCS_CNT_ONE;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= `UEPCS_CNT_ZERO;
      err0_q <= `UEPCS_RST_BIT;
      err1_q <= `UEPCS_RST_BIT;
      big0_q <= `UEPCS_RST_BIT;
      big1_q <= `UEPCS_RST_BIT;
    end
    else
    begin
      cnt_q <= cnt_d;
      err0_q <= err0_d;
      err1_q <= err1_d;
      big0_q <= big0_d;
      big1_q <= big1_d;
    end
  end

  assign full = (cnt_q == `UEPCS_CNT_TWO) || (cnt_q == `UEPCS_CNT_ONE && big0_q);
  assign ready = (cnt_q != `UEPCS_CNT_ZERO);
  assign head_err = ready & err0_q;
  assign occupancy = full ? `UEPCS_OCC_FULL : (ready ? `UEPCS_OCC_ONE : `UEPCS_OCC_EMPTY);

endmodule

// ===== src/uepcs_auto_count.v
// Byte counter that signals when a full maximum-size IN packet has been loaded
`timescale 1ns/10ps
module uepcs_auto_count
(
  input wire clk,
  input wire rst_n,
  input wire enable,
  input wire hold_clr,
  input wire byte_wr,
  input wire [3:0] max_packet_size,
  output reg hit
);
`include "uepcs_defines.vh"

  reg [6:0] count_q;
  wire [6:0] target;
  wire [3:0] units;

  // A code of zero also means eight bytes
  assign units = (max_packet_size == `UEPCS_MAX_PACKET_SIZE_ZERO) ? `UEPCS_RST_MAX_PACKET_SIZE : max_packet_size;
  assign target = {units, 3'h0};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_q <= `UEPCS_BYTE_ZERO;
      hit <= `UEPCS_RST_BIT;
    end
    else
    begin
      hit <= `UEPCS_RST_BIT;
      if (!enable || hold_clr)
        count_q <= `UEPCS_BYTE_ZERO;
      else if (byte_wr)
      begin
        if (count_q + `UEPCS_BYTE_ONE == target)
        begin
          count_q <= `UEPCS_BYTE_ZERO;
          hit <= 1'b1;
        end
        else
          count_q <= count_q + `UEPCS_BYTE_ONE;
      end
    end
  end

endmodule

// ===== src/uepcs_top.v
// Control and status register logic for one numbered USB function endpoint
`timescale 1ns/10ps
module uepcs_top
#(
  parameter EP_NUM = 1
)
(
  input wire SYS_CLK,
  input wire RESET_N,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire SIE_OUT_DONE,
  input wire SIE_OUT_BAD,
  input wire SIE_OUT_BIG,
  input wire FIFO_IN_WR,
  input wire FIFO_OUT_LAST,
  input wire IN_PKT_READY,
  output reg STALL_OUT,
  output reg OUT_FULL,
  output reg FIFO_DISCARD,
  output reg IN_SET_READY,
  output reg DIR_IN,
  output reg TYPE_ISO,
  output reg DMA_SELECT,
  output reg DMA_MARK,
  output reg [3:0] MAX_PKT
);
`include "uepcs_defines.vh"

  localparam integer CSR_ADDR_I = `UEPCS_CSR_BASE + EP_NUM * `UEPCS_CSR_STRIDE;
  localparam [7:0] CSR_ADDR = CSR_ADDR_I[7:0];

  reg out_stall_q;
  reg in_auto_q;
  reg in_iso_q;
  reg dir_in_q;
  reg dma_en_q;
  reg dma_mark_q;
  reg out_autoclr_q;
  reg out_iso_q;
  reg [3:0] max_packet_size_q;
  reg overrun_q;
  reg [31:0] rdata_d;
  wire wr_hit;
  wire rd_hit;
  wire out_dir;
  wire trk_ready;
  wire trk_full;
  wire trk_err;
  wire [1:0] trk_occ;
  wire pkt_push;
  wire pkt_drop;
  wire clr_by_write;
  wire discard_req;
  wire pkt_pop;
  wire auto_hit;

  assign wr_hit = REG_WR && (REG_ADDR == CSR_ADDR);
  assign rd_hit = REG_RD && (REG_ADDR == CSR_ADDR);
  assign out_dir = ~dir_in_q;

  // Received packet is stored unless both slots are taken or the single held packet is big, dropped otherwise
  assign pkt_push = SIE_OUT_DONE & out_dir & ~trk_full;
  assign pkt_drop = SIE_OUT_DONE & out_dir & trk_full;
  // Write of zero to packet-ready releases the head packet
  assign clr_by_write = wr_hit & out_dir & trk_ready & ~REG_WDATA[`UEPCS_B_OUT_READY];
  assign discard_req = wr_hit & out_dir & trk_ready & REG_WDATA[`UEPCS_B_OUT_DISCARD];
  assign pkt_pop = clr_by_write | discard_req |
                   (out_autoclr_q & out_dir & trk_ready & FIFO_OUT_LAST);

  uepcs_pkt_track u_track
  (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .push(pkt_push),
    .push_err(SIE_OUT_BAD),
    .push_big(SIE_OUT_BIG),
    .pop(pkt_pop),
    .occupancy(trk_occ),
    .head_err(trk_err),
    .ready(trk_ready),
    .full(trk_full)
  );

  uepcs_auto_count u_auto
  (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .enable(in_auto_q & dir_in_q),
    .hold_clr(IN_PKT_READY),
    .byte_wr(FIFO_IN_WR),
    .max_packet_size(max_packet_size_q),
    .hit(auto_hit)
  );

  // Software writable configuration
  always @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      out_stall_q <= `UEPCS_RST_BIT;
      in_auto_q <= `UEPCS_RST_BIT;
      in_iso_q <= `UEPCS_RST_BIT;
      dir_in_q <= `UEPCS_RST_DIR_IN;
      dma_en_q <= `UEPCS_RST_BIT;
      dma_mark_q <= `UEPCS_RST_BIT;
      out_autoclr_q <= `UEPCS_RST_BIT;
      out_iso_q <= `UEPCS_RST_BIT;
      max_packet_size_q <= `UEPCS_RST_MAX_PACKET_SIZE;
    end
    else if (wr_hit)
    begin
      in_auto_q <= REG_WDATA[`UEPCS_B_IN_AUTO];
      in_iso_q <= REG_WDATA[`UEPCS_B_IN_ISO];
      dir_in_q <= REG_WDATA[`UEPCS_B_DIR_IN];
      dma_en_q <= REG_WDATA[`UEPCS_B_DMA_EN];
      dma_mark_q <= REG_WDATA[`UEPCS_B_DMA_MARK];
      if (out_dir)
      begin
        out_stall_q <= REG_WDATA[`UEPCS_B_OUT_STALL];
        out_autoclr_q <= REG_WDATA[`UEPCS_B_OUT_AUTOCLR];
        out_iso_q <= REG_WDATA[`UEPCS_B_OUT_ISO];
      end
      if (REG_WDATA[`UEPCS_B_SIZE_GUARD])
        max_packet_size_q <= REG_WDATA[`UEPCS_B_MAX_PACKET_SIZE_HI:`UEPCS_B_MAX_PACKET_SIZE_LO];
    end
  end

  // Overrun: a new drop wins over the release of the head packet
  always @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      overrun_q <= `UEPCS_RST_BIT;
    else if (pkt_drop & out_iso_q)
      overrun_q <= 1'b1;
    else if (pkt_pop | dir_in_q)
      overrun_q <= `UEPCS_RST_BIT;
  end

  // Read word assembly; OUT fields read zero in IN direction
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (out_dir)
    begin
      rdata_d[`UEPCS_B_OUT_STALL] = out_stall_q;
      rdata_d[`UEPCS_B_OUT_ERR] = trk_err & out_iso_q;
      rdata_d[`UEPCS_B_OUT_OVER] = overrun_q;
      rdata_d[`UEPCS_B_OCC_HI:`UEPCS_B_OCC_LO] = trk_occ;
      rdata_d[`UEPCS_B_OUT_AUTOCLR] = out_autoclr_q;
      rdata_d[`UEPCS_B_OUT_ISO] = out_iso_q;
    end
    rdata_d[`UEPCS_B_IN_AUTO] = in_auto_q;
    rdata_d[`UEPCS_B_IN_ISO] = in_iso_q;
    rdata_d[`UEPCS_B_DIR_IN] = dir_in_q;
    rdata_d[`UEPCS_B_DMA_EN] = dma_en_q;
    rdata_d[`UEPCS_B_DMA_MARK] = dma_mark_q;
    rdata_d[`UEPCS_B_MAX_PACKET_SIZE_HI:`UEPCS_B_MAX_PACKET_SIZE_LO] = max_packet_size_q;
  end

  // Registered outputs
  always @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      REG_RDATA <= 32'h0000_0000;
      STALL_OUT <= `UEPCS_RST_BIT;
      OUT_FULL <= `UEPCS_RST_BIT;
      FIFO_DISCARD <= `UEPCS_RST_BIT;
      IN_SET_READY <= `UEPCS_RST_BIT;
      DIR_IN <= `UEPCS_RST_DIR_IN;
      TYPE_ISO <= `UEPCS_RST_BIT;
      DMA_SELECT <= `UEPCS_RST_BIT;
      DMA_MARK <= `UEPCS_RST_BIT;
      MAX_PKT <= `UEPCS_RST_MAX_PACKET_SIZE;
    end
    else
    begin
      REG_RDATA <= rd_hit ? rdata_d : 32'h0000_0000;
      STALL_OUT <= out_stall_q & out_dir;
      OUT_FULL <= trk_full & out_dir;
      FIFO_DISCARD <= discard_req;
      IN_SET_READY <= auto_hit & ~IN_PKT_READY;
      DIR_IN <= dir_in_q;
      TYPE_ISO <= dir_in_q ? in_iso_q : out_iso_q;
      DMA_SELECT <= dma_en_q;
      DMA_MARK <= dma_mark_q;
      MAX_PKT <= max_packet_size_q;
    end
  end

endmodule

// ===== test/uepcs_props.sv
// Port assertions for the endpoint control block
`timescale 1ns/10ps
module uepcs_props
#(
  parameter EP_NUM = 1
)
(
  input wire SYS_CLK,
  input wire RESET_N,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [31:0] REG_RDATA,
  input wire STALL_OUT,
  input wire FIFO_DISCARD,
  input wire IN_SET_READY,
  input wire DIR_IN,
  input wire DMA_SELECT,
  input wire DMA_MARK,
  input wire [3:0] MAX_PKT
);
  localparam [7:0] A = 8'h20 + 8'h04 * EP_NUM;
  wire wr_hit = REG_WR && REG_ADDR == A;
  wire rd_hit = REG_RD && REG_ADDR == A;
  reg hit_q;
  reg [31:0] wd_q;
  always @(posedge SYS_CLK)
  begin
    hit_q <= RESET_N && wr_hit;
    if (wr_hit)
      wd_q <= REG_WDATA;
  end
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence wr_s;
    hit_q && !wr_hit;
  endsequence
  ctl_out_a: assert property (wr_s |=> DIR_IN == wd_q[13]
    && DMA_SELECT == wd_q[12] && DMA_MARK == wd_q[11]) else $error("ctl");
  size_field_a: assert property (wr_s |=>
    MAX_PKT == (wd_q[7] ? wd_q[3:0] : $past(MAX_PKT))) else $error("size");
  stall_dir_a: assert property (STALL_OUT |-> !DIR_IN) else $error("stall");
  reserved_zero_a: assert property (rd_hit |=> REG_RDATA[31:22] == 10'h000
    && !REG_RDATA[10] && REG_RDATA[7:4] == 4'h0) else $error("rsv");
  occ_code_a: assert property (rd_hit |=> REG_RDATA[17:16] != 2'h2) else $error("occ");
  in_zero_a: assert property (rd_hit && DIR_IN && !$past(REG_WR) |=>
    REG_RDATA[21:20] == 2'h0 && REG_RDATA[18:16] == 3'h0 && REG_RDATA[9:8] == 2'h0)
    else $error("in");
  idle_read_a: assert property (!rd_hit |=> REG_RDATA == 32'h0) else $error("idle");
  discard_pulse_a: assert property ($rose(FIFO_DISCARD) |->
    ($past(wr_hit) || $past(wr_hit, 2)) ##1 !FIFO_DISCARD) else $error("disc");
  auto_pulse_a: assert property (IN_SET_READY |-> DIR_IN ##1 !IN_SET_READY)
    else $error("auto");
endmodule
bind uepcs_top uepcs_props #(.EP_NUM(EP_NUM)) u_props (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .STALL_OUT(STALL_OUT), .FIFO_DISCARD(FIFO_DISCARD),
  .IN_SET_READY(IN_SET_READY), .DIR_IN(DIR_IN), .DMA_SELECT(DMA_SELECT),
  .DMA_MARK(DMA_MARK), .MAX_PKT(MAX_PKT));

// ===== test/uepcs_sie_model.sv
// Serial engine and FIFO port model
`timescale 1ns/10ps
module uepcs_sie_model
(
  input wire clk,
  output reg done = 1'b0,
  output reg bad = 1'b0,
  output reg big = 1'b0,
  output reg in_wr = 1'b0,
  output reg out_last = 1'b0
);
  task send(input b, input g);
  begin
    @(posedge clk);
    done <= 1'b1;
    bad <= b;
    big <= g;
    @(posedge clk);
    done <= 1'b0;
    bad <= ~b;
    big <= ~g;
  end
  endtask
  task load(input integer n);
    integer i;
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge clk);
      in_wr <= 1'b1;
    end
    @(posedge clk);
    in_wr <= 1'b0;
  end
  endtask
  task unload;
  begin
    @(posedge clk);
    out_last <= 1'b1;
    @(posedge clk);
    out_last <= 1'b0;
  end
  endtask
endmodule

// ===== test/usb_endpoint_ctrl_status_test.sv
// Bench for the endpoint control block
`timescale 1ns/10ps
module usb_endpoint_ctrl_status_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] ad = 8'h00;
  reg [31:0] wd = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg in_rdy = 1'b0;
  wire [31:0] rdat;
  wire [3:0] mp;
  wire dn, bd, bg, iw, ol, st, fl, dc, sr, di, ty, ds, dm;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer n_set = 0;
  integer n_disc = 0;
  localparam [7:0] A = 8'h24;
  uepcs_top #(.EP_NUM(1)) uut (.SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(ad),
    .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .SIE_OUT_DONE(dn),
    .SIE_OUT_BAD(bd), .SIE_OUT_BIG(bg), .FIFO_IN_WR(iw), .FIFO_OUT_LAST(ol),
    .IN_PKT_READY(in_rdy), .STALL_OUT(st), .OUT_FULL(fl), .FIFO_DISCARD(dc),
    .IN_SET_READY(sr), .DIR_IN(di), .TYPE_ISO(ty), .DMA_SELECT(ds), .DMA_MARK(dm),
    .MAX_PKT(mp));
  uepcs_sie_model sie (.clk(clk), .done(dn), .bad(bd), .big(bg), .in_wr(iw),
    .out_last(ol));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sr === 1'b1)
      n_set <= n_set + 1;
    if (dc === 1'b1)
      n_disc <= n_disc + 1;
    if (cyc == 3000)
    begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task c(input [31:0] g, input [31:0] e);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task w(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task r(input [7:0] a, input [31:0] e);
  begin
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    c(rdat, e);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    r(A, 32'h00002001);
    c(mp, 4'h1);
    w(A, 32'h00002005);
    r(A, 32'h00002001);
    w(A, 32'h00002085);
    r(A, 32'h00002005);
    w(8'h28, 32'h0);
    r(8'h28, 32'h0);
    r(A, 32'h00002005);
    $display("test size done");
    w(A, 32'h0030F881);
    r(A, 32'h0000F801);
    c({ds, dm, ty}, 3'h7);
    sie.load(8);
    r(A, 32'h0000F801);
    c(n_set, 32'h1);
    @(posedge clk);
    in_rdy <= 1'b1;
    @(posedge clk);
    in_rdy <= 1'b0;
    sie.load(7);
    r(A, 32'h0000F801);
    c(n_set, 32'h1);
    $display("test in done");
    w(A, 32'h00000000);
    r(A, 32'h00000001);
    sie.send(1'b0, 1'b0);
    r(A, 32'h00010001);
    sie.send(1'b0, 1'b0);
    sie.send(1'b0, 1'b0);
    r(A, 32'h00030001);
    c(fl, 1'b1);
    w(A, 32'h00000001);
    r(A, 32'h00010001);
    w(A, 32'h00000001);
    r(A, 32'h00000001);
    w(A, 32'h00000101);
    sie.send(1'b0, 1'b0);
    sie.send(1'b1, 1'b0);
    sie.send(1'b0, 1'b0);
    r(A, 32'h00070101);
    w(A, 32'h00000301);
    r(A, 32'h00090301);
    sie.unload;
    r(A, 32'h00000301);
    sie.send(1'b0, 1'b1);
    r(A, 32'h00030301);
    w(A, 32'h00110301);
    r(A, 32'h00000301);
    w(A, 32'h00110301);
    r(A, 32'h00000301);
    c(n_disc, 32'h1);
    $display("test out done");
    w(A, 32'h00200001);
    r(A, 32'h00200001);
    c(st, 1'b1);
    w(A, 32'h00000001);
    r(A, 32'h00000001);
    c(st, 1'b0);
    $display("test stall done");
    report_and_stop;
  end
endmodule
